// ### logic/rswd_top.sv
// Reset source synchroniser and watchdog timer with an AHB-Lite register port.
// Assumes all inputs synchronous to i_sys_clk; watchdog clocks arrive as tick enables.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "rswd_defines.svh"

module rswd_top
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_imm_move_wr,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_ext_reset_pin_n,
  input wire logic i_power_on_reset,
  input wire logic i_low_voltage_reset,
  input wire logic i_lsrc_tick,
  input wire logic i_subclk_tick,
  input wire logic i_standby_enter,
  input wire logic i_standby_active,
  input wire logic i_hold_enter,
  input wire logic [15:0] i_opt_start_addr,
  output logic o_sys_reset,
  output logic o_wd_reset,
  output rswd_pkg::rswd_clksrc_t o_sysclk_src,
  output logic o_pc_load,
  output logic [15:0] o_pc_start_addr,
  output logic o_sp_clear,
  output logic o_lsrc_enable,
  output logic o_subclock_osc_enable
);

  logic [2:0] src_meta_q;
  logic [2:0] src_sync_q;
  logic full_rst;
  logic rst_q;
  rswd_pkg::rswd_aphase_t aph_q;
  rswd_pkg::rswd_ctrl_t ctrl_q;
  logic [7:0] aux_q;
  logic [16:0] wd_counter_q;
  logic clr_pend_q;
  logic wr_ctrl;
  logic wr_aux;
  logic clear_cmd;
  logic tick;
  logic paused;
  logic [16:0] lim_m1;
  logic ovf_hit;
  logic sub_loss;
  logic wd_trig;

  // Reset sources through two flip-flops each
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      src_meta_q <= 3'h0;
      src_sync_q <= 3'h0;
    end
    else
    begin
      src_meta_q <= {~i_ext_reset_pin_n, i_power_on_reset, i_low_voltage_reset};
      src_sync_q <= src_meta_q;
    end
  end

  assign full_rst = i_reset | (|src_sync_q);

  // System reset covers every source, watchdog included
  always_ff @(posedge i_sys_clk)
  begin
    rst_q <= full_rst | wd_trig;
    o_wd_reset <= wd_trig & ~full_rst;
  end

  assign o_sys_reset = rst_q;

  // Bus address phase
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      aph_q <= '0;
    end
    else
    begin
      aph_q.valid <= i_hsel & i_htrans[1] & i_hready;
      aph_q.write <= i_hwrite;
      aph_q.imm <= i_imm_move_wr;
      aph_q.addr <= i_haddr;
    end
  end

  assign o_hreadyout = 1'h1;
  assign o_hresp = 1'h0;

  assign wr_ctrl = aph_q.valid & aph_q.write & (aph_q.addr == `RSWD_IDX2ADDR(`RSWD_CTRL_IDX));
  assign wr_aux = aph_q.valid & aph_q.write & (aph_q.addr == `RSWD_IDX2ADDR(`RSWD_AUX_IDX));
  assign clear_cmd = wr_ctrl & ctrl_q.wd_run & aph_q.imm & (i_hwdata[7:0] == `RSWD_CLEAR_CODE);

  // Read data captured at the address phase
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_hrdata <= 32'h0000_0000;
    end
    else if (i_hsel & i_htrans[1] & i_hready & ~i_hwrite)
    begin
      if (i_haddr == `RSWD_IDX2ADDR(`RSWD_CTRL_IDX))
      begin
        o_hrdata <= {24'h000000, ctrl_q};
      end
      else if (i_haddr == `RSWD_IDX2ADDR(`RSWD_AUX_IDX))
      begin
        o_hrdata <= {24'h000000, aux_q};
      end
      else if (i_haddr == `RSWD_IDX2ADDR(`RSWD_CNT_IDX))
      begin
        o_hrdata <= {15'h0000, wd_counter_q};
      end
      else
      begin
        o_hrdata <= 32'h0000_0000;
      end
    end
  end

  // Watchdog clock, pause and overflow detection
  assign tick = ctrl_q.wd_clock_select ? i_subclk_tick : i_lsrc_tick;
  assign paused = i_standby_active & (ctrl_q.standby_action == rswd_pkg::RSWD_SB_PAUSE);
  assign lim_m1 = 17'((`RSWD_OVF_BASE << ctrl_q.overflow_sel) - 18'h00001);
  assign ovf_hit = tick & ~paused & ~clr_pend_q & (wd_counter_q == lim_m1);
  assign sub_loss = ctrl_q.wd_clock_select & (~aux_q[`RSWD_AUX_SUBOSC_BIT] | i_hold_enter);
  assign wd_trig = ctrl_q.wd_run & (ovf_hit | sub_loss);

  // Control register
  always_ff @(posedge i_sys_clk)
  begin
    if (full_rst)
    begin
      ctrl_q <= `RSWD_CTRL_RESET;
    end
    else if (wd_trig)
    begin
      ctrl_q.wd_run <= 1'h0;
      ctrl_q.wd_reset_flag <= 1'h1;
    end
    else
    begin
      if (wr_ctrl & ~ctrl_q.wd_run)
      begin
        ctrl_q <= i_hwdata[7:0];
      end
      if (i_standby_enter & ctrl_q.wd_run & (ctrl_q.standby_action == rswd_pkg::RSWD_SB_STOP))
      begin
        ctrl_q.wd_run <= 1'h0;
      end
    end
  end

  // Auxiliary register, back to defaults on every reset
  always_ff @(posedge i_sys_clk)
  begin
    if (full_rst | rst_q)
    begin
      aux_q <= `RSWD_AUX_RESET;
    end
    else if (wr_aux)
    begin
      aux_q <= i_hwdata[7:0];
    end
  end

  // Clear command held until the watchdog clock takes it
  always_ff @(posedge i_sys_clk)
  begin
    if (full_rst | ~ctrl_q.wd_run)
    begin
      clr_pend_q <= 1'h0;
    end
    else if (clear_cmd)
    begin
      clr_pend_q <= 1'h1;
    end
    else if (tick)
    begin
      clr_pend_q <= 1'h0;
    end
  end

  // Watchdog counter
  always_ff @(posedge i_sys_clk)
  begin
    if (full_rst | ~ctrl_q.wd_run)
    begin
      wd_counter_q <= 17'h00000;
    end
    else if (tick & ~paused)
    begin
      if (clr_pend_q | ovf_hit)
      begin
        wd_counter_q <= 17'h00000;
      end
      else
      begin
        wd_counter_q <= 17'(wd_counter_q + 17'h00001);
      end
    end
  end

  // Clock source, start address, stack pointer and oscillator enables
  always_ff @(posedge i_sys_clk)
  begin
    if (full_rst | rst_q)
    begin
      o_sysclk_src <= rswd_pkg::RSWD_CLK_MRC;
    end
    else
    begin
      o_sysclk_src <= aux_q[`RSWD_AUX_MAINCLK_BIT] ? rswd_pkg::RSWD_CLK_MAIN : rswd_pkg::RSWD_CLK_MRC;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    o_pc_load <= full_rst | rst_q;
    o_sp_clear <= full_rst | rst_q;
    if (full_rst | rst_q)
    begin
      o_pc_start_addr <= i_opt_start_addr;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_lsrc_enable <= 1'h0;
      o_subclock_osc_enable <= 1'h0;
    end
    else
    begin
      o_lsrc_enable <= (~ctrl_q.wd_clock_select & ctrl_q.wd_run) | aux_q[`RSWD_AUX_LSRC_BIT];
      o_subclock_osc_enable <= aux_q[`RSWD_AUX_SUBOSC_BIT];
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_clear_issued;
    clear_cmd && !full_rst && !wd_trig;
  endsequence

  sequence s_clear_taken;
    ctrl_q.wd_run && !full_rst && tick && !paused;
  endsequence

  a_src_sync_delay: assert property ((!i_ext_reset_pin_n) [*3] |=> o_sys_reset)
    else $error("pin reset not seen on system reset");

  a_reset_clk_mrc: assert property (o_sys_reset |=> o_sysclk_src == rswd_pkg::RSWD_CLK_MRC)
    else $error("system clock not medium RC after reset");

  a_pc_start_load: assert property (o_sys_reset |=> o_pc_load && o_pc_start_addr == $past(i_opt_start_addr))
    else $error("start address not loaded on reset");

  a_sp_clear: assert property (o_sys_reset |=> o_sp_clear)
    else $error("stack pointer clear missing");

  a_count_advance: assert property (ctrl_q.wd_run && tick && !paused && !clr_pend_q && !wd_trig && !full_rst
    |=> wd_counter_q == 17'($past(wd_counter_q) + 17'h00001))
    else $error("counter did not advance on tick");

  a_ovf_reset: assert property (ctrl_q.wd_run && !full_rst && tick && !paused && !clr_pend_q
    && wd_counter_q == 17'((`RSWD_OVF_BASE << ctrl_q.overflow_sel) - 18'h00001)
    |=> o_wd_reset && o_sys_reset && ctrl_q.wd_reset_flag && !ctrl_q.wd_run)
    else $error("overflow did not reset");

  a_wd_keep_bits: assert property (wd_trig && !full_rst
    |=> (ctrl_q & `RSWD_CTRL_KEEP_MASK) == ($past(ctrl_q) & `RSWD_CTRL_KEEP_MASK))
    else $error("watchdog reset altered kept bits");

  a_full_clear: assert property (full_rst |=> ctrl_q == `RSWD_CTRL_RESET)
    else $error("control not cleared by full reset");

  a_write_lock: assert property (wr_ctrl && ctrl_q.wd_run && !wd_trig && !full_rst && !i_standby_enter
    |=> ctrl_q == $past(ctrl_q))
    else $error("locked control register changed");

  a_clear_cmd: assert property (s_clear_issued ##1 s_clear_taken |=> wd_counter_q == 17'h00000)
    else $error("clear command did not zero counter");

  a_stopped_zero: assert property (!ctrl_q.wd_run |=> wd_counter_q == 17'h00000)
    else $error("counter not zero while stopped");

  a_lsrc_enable: assert property ((!ctrl_q.wd_clock_select && ctrl_q.wd_run) || aux_q[`RSWD_AUX_LSRC_BIT]
    |=> o_lsrc_enable)
    else $error("low-speed RC not enabled");

  a_subclk_loss: assert property (ctrl_q.wd_run && ctrl_q.wd_clock_select && !full_rst
    && (!aux_q[`RSWD_AUX_SUBOSC_BIT] || i_hold_enter) |=> o_wd_reset && ctrl_q.wd_reset_flag)
    else $error("subclock loss did not reset");

  a_pause_hold: assert property (ctrl_q.wd_run && paused && !full_rst
    |=> wd_counter_q == $past(wd_counter_q))
    else $error("counter moved while paused");

  a_standby_stop: assert property (i_standby_enter && ctrl_q.wd_run && !full_rst
    && ctrl_q.standby_action == rswd_pkg::RSWD_SB_STOP |=> !ctrl_q.wd_run)
    else $error("stop encoding left watchdog running");

  a_wd_one_pulse: assert property (o_wd_reset |=> !o_wd_reset)
    else $error("watchdog reset pulse longer than one cycle");

  a_sys_on_wd: assert property (o_wd_reset |-> o_sys_reset)
    else $error("watchdog reset missing from system reset");

  a_clear_pending: assert property (clear_cmd && !full_rst |=> clr_pend_q)
    else $error("clear command not held for watchdog clock");

  a_aux_on_reset: assert property (o_sys_reset |=> aux_q == `RSWD_AUX_RESET)
    else $error("auxiliary register not reset");

  a_trig_cnt_zero: assert property (wd_trig && !full_rst |-> ##2 wd_counter_q == 17'h00000)
    else $error("counter not zero after watchdog reset");

  a_read_ctrl: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
    && i_haddr == `RSWD_IDX2ADDR(`RSWD_CTRL_IDX) |=> o_hrdata == {24'h000000, $past(ctrl_q)})
    else $error("control read data wrong");

endmodule // rswd_top

// ### logic/rswd_defines.svh
// Offsets, field positions, reset values and timing counts of the reset and watchdog block.
// Assumes a 20 MHz system clock and a single AHB-Lite slave port.
// Contract
// - All reset sources reach logic clock-synchronised
// - Any reset selects medium-speed RC system clock
// - Reset loads option start address, SFR defaults
// - Reset clears stack pointer, RAM untouched
// - Seventeen-bit up-counter advances while run set
// - Bit 6 picks low-speed RC or subclock
// - Selected count reached: reset, clear run, flag
// - Overflow count is 1024 shifted by select
// - Full resets clear control; watchdog keeps bits
// - Running locks control writes; reads still work
// - Only immediate-move 55H clears running counter
// - Counter zero when stopped or on clear
// - Bit 5 starts and stops watchdog
// - Bit 7 flag: watchdog sets, others clear
// - Low-speed RC on by watchdog or start bit
// - Subclock loss or HOLD entry forces reset
// - Standby action: count, stop, or pause
// - Bits 4:3: 00/11 count, 01 stop, 10 pause
// - Standby entry with stop encoding clears run
`ifndef RSWD_DEFINES_SVH
`define RSWD_DEFINES_SVH

// Register indices; the byte address is four times the index
`define RSWD_CTRL_IDX 16'hFE79
`define RSWD_AUX_IDX 16'hFE7A
`define RSWD_CNT_IDX 16'hFE7B
`define RSWD_IDX2ADDR(idx) ({14'h0000, (idx), 2'h0})

// Control register
`define RSWD_CTRL_RESET 8'h00
`define RSWD_CTRL_KEEP_MASK 8'h5F
`define RSWD_CLEAR_CODE 8'h55

// Auxiliary register: start bit, main clock select, subclock oscillator enable
`define RSWD_AUX_RESET 8'h00
`define RSWD_AUX_LSRC_BIT 0
`define RSWD_AUX_MAINCLK_BIT 1
`define RSWD_AUX_SUBOSC_BIT 6

// Overflow base count
`define RSWD_OVF_BASE 18'h00400

// Timing
`define RSWD_CLK_HZ 20000000
`define RSWD_EXT_RST_MIN_NS 200000
`define RSWD_EXT_RST_MIN_CYC ((`RSWD_EXT_RST_MIN_NS * (`RSWD_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ### logic/rswd_pkg.sv
// Types of the reset and watchdog block.
// Assumes rswd_defines.svh holds every number.
package rswd_pkg;

  typedef enum logic [1:0] {
    RSWD_SB_COUNT = 2'h0,
    RSWD_SB_STOP = 2'h1,
    RSWD_SB_PAUSE = 2'h2,
    RSWD_SB_COUNT_ALT = 2'h3
  } rswd_sb_t;

  typedef enum logic [1:0] {
    RSWD_CLK_MRC = 2'h0,
    RSWD_CLK_MAIN = 2'h1
  } rswd_clksrc_t;

  typedef struct packed {
    logic wd_reset_flag;
    logic wd_clock_select;
    logic wd_run;
    rswd_sb_t standby_action;
    logic [2:0] overflow_sel;
  } rswd_ctrl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic imm;
    logic [31:0] addr;
  } rswd_aphase_t;

endpackage

// ### test/rswd_cpu.sv
// CPU model: AHB-Lite master doing single word transfers.
// Assumes the slave's hreadyout is fed back as i_hready.
module rswd_cpu
(
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata,
  output logic o_imm,
  output logic o_hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
    o_imm = 1'b0;
    o_hung = 1'b0;
  end
  // Wait for hready under a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_hready !== 1'b1 && n < 64);
    o_hung <= (i_hready !== 1'b1);
  endtask
  // One transfer: address phase, then data phase
  task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d, input logic m,
    output logic [31:0] r);
    o_haddr <= a;
    o_htrans <= 2'h2;
    o_hwrite <= w;
    o_imm <= m;
    wait_rdy();
    o_htrans <= 2'h0;
    o_imm <= 1'b0;
    o_hwdata <= d;
    wait_rdy();
    r = i_hrdata;
    o_hwdata <= ~d;
  endtask
endmodule // rswd_cpu

// ### test/rswd_top_bench.sv
// Bench of the reset and watchdog block, driven through the CPU model.
// Assumes the design files and rswd_cpu are compiled first.
`include "rswd_defines.svh"

module rswd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] adr_ctrl = `RSWD_IDX2ADDR(`RSWD_CTRL_IDX);
  localparam logic [31:0] adr_aux = `RSWD_IDX2ADDR(`RSWD_AUX_IDX);
  localparam logic [31:0] adr_cnt = `RSWD_IDX2ADDR(`RSWD_CNT_IDX);
  localparam logic [15:0] start_adr = 16'hA5C0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin_n = 1'b1;
  logic por = 1'b0;
  logic lv_rst = 1'b0;
  logic hold = 1'b0;
  logic lt = 1'b0;
  logic st = 1'b0;
  logic sb_ent = 1'b0;
  logic sb_act = 1'b0;
  logic rdy, resp, hwr, imm, hung, sys_rst, wd_rst, pc_ld, sp_clr, lsrc_en, sub_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] pc_adr;
  rswd_pkg::rswd_clksrc_t clk_src;
  int fails = 0;
  int checks_done = 0;
  int n;
  always #25 clk = ~clk;
  rswd_cpu i_cpu (.i_clk(clk), .i_hready(rdy), .i_hrdata(hrdata), .o_haddr(haddr), .o_htrans(htrans),
    .o_hwrite(hwr), .o_hsize(hsize), .o_hwdata(hwdata), .o_imm(imm), .o_hung(hung));
  rswd_top i_dut (.i_sys_clk(clk), .i_reset(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwr), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy), .i_imm_move_wr(imm),
    .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata), .i_ext_reset_pin_n(pin_n),
    .i_power_on_reset(por), .i_low_voltage_reset(lv_rst), .i_lsrc_tick(lt), .i_subclk_tick(st),
    .i_standby_enter(sb_ent), .i_standby_active(sb_act), .i_hold_enter(hold),
    .i_opt_start_addr(start_adr), .o_sys_reset(sys_rst), .o_wd_reset(wd_rst), .o_sysclk_src(clk_src),
    .o_pc_load(pc_ld), .o_pc_start_addr(pc_adr), .o_sp_clear(sp_clr), .o_lsrc_enable(lsrc_en),
    .o_subclock_osc_enable(sub_en));
  task automatic finish_test();
    if (fails == 0 && checks_done > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang();
    fails++;
    finish_test();
  endtask
  always @(posedge hung) hang();
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk1(input string s, input logic e, input logic g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic m = 1'b0);
    i_cpu.access(a, 1'b1, {24'h0, d}, m, rd);
  endtask
  task automatic rd_chk(input string s, input logic [31:0] a, input logic [31:0] e);
    i_cpu.access(a, 1'b0, 32'h0, 1'b0, rd);
    chk(s, e, rd);
  endtask
  task automatic ticks(input logic sub, input int k);
    repeat (k)
    begin
      lt <= !sub;
      st <= sub;
      @(posedge clk);
    end
    lt <= 1'b0;
    st <= 1'b0;
    @(posedge clk);
  endtask
  task automatic full_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk1("sys_rst", 1'b1, sys_rst);
    chk1("pc_load", 1'b1, pc_ld);
    chk1("sp_clear", 1'b1, sp_clr);
    repeat (3) @(posedge clk);
    chk("pc_adr", {16'h0, start_adr}, {16'h0, pc_adr});
    chk("clk_src", 32'(rswd_pkg::RSWD_CLK_MRC), 32'(clk_src));
    chk1("hresp", 1'b0, resp);
    rd_chk("ctrl_init", adr_ctrl, 32'h0);
    rd_chk("unmapped", adr_ctrl + 32'h10, 32'h0);
    wr(adr_ctrl, 8'h1F);
    rd_chk("ctrl_free", adr_ctrl, 32'h1F);
    wr(adr_ctrl, 8'h20);
    rd_chk("ctrl_run", adr_ctrl, 32'h20);
    chk1("lsrc_wd", 1'b1, lsrc_en);
    wr(adr_ctrl, 8'h07);
    rd_chk("ctrl_lock", adr_ctrl, 32'h20);
    ticks(1'b1, 4);
    rd_chk("cnt_sub", adr_cnt, 32'h0);
    ticks(1'b0, 5);
    rd_chk("cnt", adr_cnt, 32'h5);
    wr(adr_ctrl, 8'h55);
    ticks(1'b0, 1);
    rd_chk("cnt_plain", adr_cnt, 32'h6);
    wr(adr_ctrl, 8'h55, 1'b1);
    ticks(1'b0, 1);
    rd_chk("cnt_clr", adr_cnt, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      full_reset();
      wr(adr_ctrl, 8'h38 | 8'(s));
      n = 0;
      lt <= 1'b1;
      sb_act <= 1'b1;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (wd_rst !== 1'b1 && n < 9000);
      lt <= 1'b0;
      sb_act <= 1'b0;
      chk("ovf_n", (32'h400 << s) + 32'h1, n);
      if (n >= 9000)
      begin
        hang();
      end
      chk1("wd_sys", 1'b1, sys_rst);
      @(posedge clk);
      chk1("wd_pulse", 1'b0, wd_rst);
      chk1("wd_sys_end", 1'b0, sys_rst);
      repeat (3) @(posedge clk);
      rd_chk("ctrl_wd", adr_ctrl, 32'h98 | s);
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(adr_ctrl, 8'h80);
      rd_chk("flag_sw", adr_ctrl, 32'h80);
      pin_n <= (k != 0);
      por <= (k == 1);
      lv_rst <= (k == 2);
      repeat ((k == 0) ? 4000 : 5) @(posedge clk);
      chk1("src_rst", 1'b1, sys_rst);
      pin_n <= 1'b1;
      por <= 1'b0;
      lv_rst <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk("ctrl_src", adr_ctrl, 32'h0);
    end
    wr(adr_ctrl, 8'h28);
    sb_ent <= 1'b1;
    @(posedge clk);
    sb_ent <= 1'b0;
    @(posedge clk);
    rd_chk("sb_stop", adr_ctrl, 32'h08);
    wr(adr_ctrl, 8'h30);
    sb_act <= 1'b1;
    ticks(1'b0, 5);
    rd_chk("cnt_hold", adr_cnt, 32'h0);
    sb_act <= 1'b0;
    ticks(1'b0, 3);
    rd_chk("cnt_resume", adr_cnt, 32'h3);
    full_reset();
    wr(adr_aux, 8'h43);
    rd_chk("aux", adr_aux, 32'h43);
    chk1("lsrc_bit", 1'b1, lsrc_en);
    chk1("sub_en", 1'b1, sub_en);
    chk("clk_main", 32'(rswd_pkg::RSWD_CLK_MAIN), 32'(clk_src));
    wr(adr_ctrl, 8'h60);
    ticks(1'b0, 2);
    ticks(1'b1, 3);
    rd_chk("cnt_subclk", adr_cnt, 32'h3);
    wr(adr_aux, 8'h03);
    n = 0;
    while (wd_rst !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    chk1("sub_loss", 1'b1, wd_rst);
    repeat (4) @(posedge clk);
    rd_chk("ctrl_loss", adr_ctrl, 32'hC0);
    chk("clk_back", 32'(rswd_pkg::RSWD_CLK_MRC), 32'(clk_src));
    wr(adr_aux, 8'h40);
    wr(adr_ctrl, 8'h60);
    hold <= 1'b1;
    @(posedge clk);
    hold <= 1'b0;
    n = 0;
    while (wd_rst !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    chk1("hold_loss", 1'b1, wd_rst);
    repeat (4) @(posedge clk);
    rd_chk("ctrl_hold", adr_ctrl, 32'hC0);
    finish_test();
  end
endmodule // rswd_top_bench
